// ### hdl/wdcs_top.sv
`timescale 1ns/1ns
// Contract
// R1 - on timeout expiry the status flag becomes set
// R2 - status flag cleared only by software zero write or hardware reset
// R3 - setting the enable bit enables the watchdog and clears its counter
// R4 - missed restart raises system reset or interrupt per mode bit
// R5 - enable cleared by zero write, reset-mode expiry, hardware reset, supply monitor
// R6 - interrupt mode request is fixed priority and never masked globally
// R7 - as plain timer the prescaler sets the interrupt period
// R8 - software first sets the write-enable bit
// R9 - the very next access must be the control register write
// R10 - control write ignored unless just armed; arming ends after one access
module wdcs_top #(
    parameter int unsigned BASE_CYCLES = 4096,
    parameter int unsigned CNT_W       = 32
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire wdcs_pkg::wdcs_req_t busReq,
    output logic [7:0]             rdData,
    input  wire logic              supplyMonitorIrq,
    output logic                   wdtResetReq,
    output logic                   wdtIrq
);
    import wdcs_pkg::*;

    logic               armed_r;
    logic               enable_r;
    logic               status_r;
    logic               irqSel_r;
    logic [PRESC_W-1:0] presc_r;
    logic [CNT_W-1:0]   cnt_r;
    logic               psmS1_r;
    logic               psmS2_r;
    logic               psmS3_r;
    logic               psmLevel_r;
    logic               resetReq_r;
    logic               irqReq_r;
    logic [DATA_W-1:0]  rdData_r;
    logic [DATA_W-1:0]  regView;

    logic               ctrlHit;
    logic               ctrlWr;
    logic               armWr;
    logic               anyStrobe;
    logic               expire;
    logic [CNT_W-1:0]   limit;

    assign ctrlHit   = (busReq.addr == CTRL_ADDR);
    assign anyStrobe = busReq.wr | busReq.rd;
    assign ctrlWr    = busReq.wr && ctrlHit && armed_r;                          // see R10
    assign armWr     = busReq.wr && ctrlHit && !armed_r && busReq.wdata[BIT_WR_EN];
    // prescaler doubles the period per step; encoding kept simple on purpose
    assign limit     = CNT_W'(BASE_CYCLES) << presc_r;                           // see R7
    assign expire    = enable_r && (cnt_r == limit - CNT_W'(1));

    assign rdData      = rdData_r;
    assign wdtResetReq = resetReq_r;
    assign wdtIrq      = irqReq_r;

    ////////////////////////////////////////////////////////////////////////////////
    // supply monitor input: three stages, level moves once stages two and three agree
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            psmS1_r    <= 1'b0;
            psmS2_r    <= 1'b0;
            psmS3_r    <= 1'b0;
            psmLevel_r <= 1'b0;
        end else begin
            psmS1_r <= supplyMonitorIrq;
            psmS2_r <= psmS1_r;
            psmS3_r <= psmS2_r;
            if (psmS2_r == psmS3_r) begin
                psmLevel_r <= psmS3_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write-enable arming: any other access in between disarms
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            armed_r <= 1'b0;
        end else if (armWr) begin
            armed_r <= 1'b1;                                                     // see R8
        end else if (anyStrobe) begin
            armed_r <= 1'b0;                                                     // see R9, R10
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // enable, mode and prescaler
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            enable_r <= 1'b0;                                                    // see R5
            irqSel_r <= 1'b0;
            presc_r  <= PRESC_RESET;
        end else begin
            if (ctrlWr) begin
                irqSel_r <= busReq.wdata[BIT_IRQ_SEL];
                presc_r  <= busReq.wdata[PRESC_LSB +: PRESC_W];
            end
            if (psmLevel_r) begin
                enable_r <= 1'b0;                                                // see R5
            end else if (ctrlWr) begin
                enable_r <= busReq.wdata[BIT_ENABLE];                            // see R3, R5
            end else if (expire && !irqSel_r) begin
                enable_r <= 1'b0;                                                // see R5
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // timeout counter; in interrupt mode it wraps so the block runs as a periodic timer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (ctrlWr && busReq.wdata[BIT_ENABLE]) begin
            cnt_r <= '0;                                                         // see R3
        end else if (!enable_r || expire) begin
            cnt_r <= '0;                                                         // see R7
        end else begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status flag: expiry beats a same-cycle software clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= 1'b0;                                                    // see R2
        end else if (expire) begin
            status_r <= 1'b1;                                                    // see R1
        end else if (ctrlWr && !busReq.wdata[BIT_STATUS]) begin
            status_r <= 1'b0;                                                    // see R2
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // expiry outputs; the interrupt has no mask path at all
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            resetReq_r <= 1'b0;
            irqReq_r   <= 1'b0;
        end else begin
            resetReq_r <= expire && !irqSel_r;                                   // see R4
            irqReq_r   <= expire && irqSel_r;                                    // see R4, R6
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register view built from the field positions, so the layout lives in one place
    always_comb begin
        regView                       = READ_ZERO;
        regView[BIT_WR_EN]            = armed_r;
        regView[BIT_ENABLE]           = enable_r;
        regView[BIT_STATUS]           = status_r;
        regView[BIT_IRQ_SEL]          = irqSel_r;
        regView[PRESC_LSB +: PRESC_W] = presc_r;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read port, data valid one cycle after the strobe only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdData_r <= READ_ZERO;
        end else if (busReq.rd && ctrlHit) begin
            rdData_r <= regView;
        end else begin
            rdData_r <= READ_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    AST_STATUS_SET: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R1
        expire |=> status_r ##1 status_r || $past(ctrlWr))
        else $error("status flag not set after expiry");

    AST_STATUS_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R2
        status_r && !(ctrlWr && !busReq.wdata[BIT_STATUS]) |=> status_r)
        else $error("status flag dropped without software clear");

    AST_ENABLE_RESTART: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R3
        ctrlWr && busReq.wdata[BIT_ENABLE] && !psmLevel_r |=> enable_r && cnt_r == '0 ##1 cnt_r == CNT_W'(1))
        else $error("enable write did not restart counter");

    AST_RESET_OUT: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R4
        expire && !irqSel_r |=> wdtResetReq && !wdtIrq ##1 !wdtResetReq)
        else $error("reset request missing or too long");

    AST_PSM_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R5
        psmLevel_r |=> !enable_r)
        else $error("supply monitor did not clear enable");

    AST_RESET_MODE_DISABLE: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R5
        expire && !irqSel_r && !ctrlWr |=> !enable_r && !psmLevel_r || !enable_r)
        else $error("enable kept after reset-mode expiry");

    AST_IRQ_OUT: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R6
        expire && irqSel_r |=> wdtIrq && !wdtResetReq)
        else $error("interrupt not raised in interrupt mode");

    AST_TIMER_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R7
        wdtIrq && enable_r |-> cnt_r == '0 && $past(cnt_r) == $past(limit) - CNT_W'(1))
        else $error("timer did not wrap at prescaled period");

    AST_GUARD: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R10
        busReq.wr && ctrlHit && !armed_r && !psmLevel_r && !expire
        |=> enable_r == $past(enable_r) && irqSel_r == $past(irqSel_r) && presc_r == $past(presc_r))
        else $error("unguarded control write took effect");

    AST_DISARM: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R10
        anyStrobe && !armWr |=> !armed_r)
        else $error("write enable survived an access");

    AST_ARM: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R8
        armWr |=> armed_r)
        else $error("arming write did not set write enable");

    AST_STATUS_WINS: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R1
        expire && ctrlWr && !busReq.wdata[BIT_STATUS] |=> status_r)
        else $error("same-cycle clear beat the expiry");

    AST_PULSE_ONE: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R4
        wdtResetReq || wdtIrq |=> !wdtResetReq && !wdtIrq)
        else $error("expiry pulse longer than one cycle");

endmodule

// ### hdl/wdcs_pkg.sv
package wdcs_pkg;

    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned PRESC_W     = 4;

    // control register location on the plain register port
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;

    // control register field positions
    localparam int unsigned BIT_WR_EN   = 0;
    localparam int unsigned BIT_ENABLE  = 1;
    localparam int unsigned BIT_STATUS  = 2;
    localparam int unsigned BIT_IRQ_SEL = 3;
    localparam int unsigned PRESC_LSB   = 4;

    localparam logic [DATA_W-1:0]  READ_ZERO   = 8'h00;
    localparam logic [PRESC_W-1:0] PRESC_RESET = 4'h0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } wdcs_req_t;

endpackage

// ### sim/wdcs_top_tb.sv
`timescale 1ns/1ns
module wdcs_top_tb;
    import wdcs_pkg::*;
    localparam int unsigned BASE = 8;
    logic            clk_sys = 1'b0;
    logic            rst_n = 1'b0;
    wdcs_req_t       busReq = '0;
    logic [7:0]      rdData;
    logic            supplyMonitorIrq = 1'b0;
    logic            wdtResetReq;
    logic            wdtIrq;
    int              mismatches = 0;
    int              n_checks = 0;
    int              cycles = 0;
    // rows: {is read, address, write data or expected read}
    localparam logic [16:0] ROWS [9] = '{17'h00001, 17'h10001, 17'h10000, 17'h0000A, 17'h10000,
                                         17'h00001, 17'h0050A, 17'h10000, 17'h10500};
    always #2 clk_sys = ~clk_sys;
    wdcs_top #(.BASE_CYCLES(BASE), .CNT_W(32)) uut (
        .clk_sys          (clk_sys),
        .rst_n            (rst_n),
        .busReq           (busReq),
        .rdData           (rdData),
        .supplyMonitorIrq (supplyMonitorIrq),
        .wdtResetReq      (wdtResetReq),
        .wdtIrq           (wdtIrq)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // strobe for one cycle; returns at the edge that takes it
    task automatic busOp(input logic isRd, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        busReq <= '{addr: a, wdata: d, wr: ~isRd, rd: isRd};
        @(posedge clk_sys);
        busReq <= '0;
        #1;
        if (isRd) chk(rdData, d);
    endtask
    task automatic guarded(input logic [7:0] d);
        busOp(1'b0, CTRL_ADDR, 8'h01);
        busOp(1'b0, CTRL_ADDR, d);
    endtask
    // counts edges from the taking edge to the pulse, checks which line fired
    task automatic waitPulse(input int expN, input logic irqMode);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
            #1;
        end while (wdtResetReq !== 1'b1 && wdtIrq !== 1'b1 && n < 300);
        chk(n, expN);
        chk({wdtIrq, wdtResetReq}, irqMode ? 2'b10 : 2'b01);
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        busOp(1'b1, CTRL_ADDR, 8'h00);
        foreach (ROWS[i]) busOp(ROWS[i][16], ROWS[i][15:8], ROWS[i][7:0]);
        // reset mode: single shot, enable drops and status stays set until a zero write clears it
        guarded(8'h02);
        waitPulse(BASE, 1'b0);
        busOp(1'b1, CTRL_ADDR, 8'h04);
        guarded(8'h00);
        busOp(1'b1, CTRL_ADDR, 8'h00);
        // interrupt mode, prescaler 1: restart mid-period, then repeat
        guarded(8'h1A);
        repeat (10) @(posedge clk_sys);
        guarded(8'h1A);
        waitPulse(BASE << 1, 1'b1);
        waitPulse(BASE << 1, 1'b1);
        // clearing write lands on the expiry edge; the expiry must win
        repeat ((BASE << 1) - 4) @(posedge clk_sys);
        guarded(8'h1A);
        chk(wdtIrq, 1'b1);
        busOp(1'b1, CTRL_ADDR, 8'h1E);
        // supply monitor drops the enable, other fields stay
        @(posedge clk_sys);
        supplyMonitorIrq <= 1'b1;
        repeat (8) @(posedge clk_sys);
        busOp(1'b1, CTRL_ADDR, 8'h1C);
        // hardware reset after the supply monitor has stopped the watchdog clears the status flag
        @(posedge clk_sys);
        supplyMonitorIrq <= 1'b0;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        busOp(1'b1, CTRL_ADDR, 8'h00);
        finish_test();
    end
endmodule
